// >>> inc/sdlcr_pkg.sv
// Package with the register map, field layout and codes of the serial lane configuration bank.
`default_nettype none

package sdlcr_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned SEL_W  = 6;
    localparam int unsigned STEP_W = 3;

    // Register offsets.
    localparam logic [7:0] LANE1_DEEMPH_OFF = 8'h12;
    localparam logic [7:0] LANE0_DEEMPH_OFF = 8'h13;
    localparam logic [7:0] LANE2_DEEMPH_OFF = 8'h14;
    localparam logic [7:0] LANE3_DEEMPH_OFF = 8'h15;
    localparam logic [7:0] PLL_MULT_OFF     = 8'h16;
    localparam logic [7:0] PLL_RST_PD_OFF   = 8'h17;
    localparam logic [7:0] STATUS_OFF       = 8'h18;

    // Field positions.
    localparam int unsigned DEEMPH_LSB      = 2;
    localparam int unsigned DEEMPH_MSB      = 7;
    localparam int unsigned PLL_MULT_LSB    = 0;
    localparam int unsigned PLL_MULT_MSB    = 1;
    localparam int unsigned PLL_RST_BIT     = 6;
    localparam int unsigned LANE_OFF_HI_BIT = 5;
    localparam int unsigned LANE_OFF_LO_BIT = 3;
    localparam int unsigned ST_PD_BIT       = 0;
    localparam int unsigned ST_BADCODE_BIT  = 1;
    localparam int unsigned ST_PULSED_BIT   = 2;
    localparam int unsigned ST_RSVD_BIT     = 3;

    // Masks of the writable bits; everything else is reserved.
    localparam logic [7:0] DEEMPH_MASK   = 8'hFC;
    localparam logic [7:0] PLL_MULT_MASK = 8'h03;
    localparam logic [7:0] PLL_RST_MASK  = 8'h68;

    // Values after reset.
    localparam logic [5:0] DEEMPH_RST   = 6'h00;
    localparam logic [1:0] PLL_MULT_RST = 2'h0;
    localparam logic [7:0] RDATA_RST    = 8'h00;

    // Multiplier codes.
    localparam logic [1:0] PLL_MULT_20X = 2'h0;
    localparam logic [1:0] PLL_MULT_40X = 2'h2;

    typedef enum logic [2:0] {
        SDLCR_PR_IDLE = 3'h1,
        SDLCR_PR_HIGH = 3'h2,
        SDLCR_PR_DONE = 3'h4
    } sdlcr_pr_state_t;

endpackage : sdlcr_pkg

`default_nettype wire

// >>> src/sdlcr_lane_drv.sv
// One transmitter lane: registered de-emphasis select, step count and code check.
`default_nettype none

module sdlcr_lane_drv
    import sdlcr_pkg::*;
#(
    parameter int unsigned SW = SEL_W
) (
    input  wire logic          clk_i,
    input  wire logic          rstn_i,
    input  wire logic [SW-1:0] sel_i,
    output var  logic [SW-1:0] sel_o,
    output var  logic [2:0]    steps_o,
    output var  logic          thermo_ok_o
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [SW-1:0] next_sel;
    logic [2:0]    next_steps;
    logic          next_thermo_ok;

    // A legal code is a run of ones from bit 0 upward; the step count is the number of set bits.
    always_comb begin
        next_sel       = sel_i;
        next_steps     = 3'h0;
        next_thermo_ok = 1'b1;
        for (int i = 0; i < SW; i++) begin
            if (sel_i[i]) begin
                next_steps = 3'(next_steps + 3'h1);
            end
        end
        // The gap search starts at bit 1 so that no select ever reaches below bit 0.
        for (int i = 1; i < SW; i++) begin
            if (sel_i[i] && !sel_i[i-1]) begin
                next_thermo_ok = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_o       <= SW'(DEEMPH_RST);
            steps_o     <= 3'h0;
            thermo_ok_o <= 1'b1;
        end else begin
            sel_o       <= next_sel;
            steps_o     <= next_steps;
            thermo_ok_o <= next_thermo_ok;
        end
    end

endmodule : sdlcr_lane_drv

`default_nettype wire

// >>> src/sdlcr_regs.sv
// Configuration register bank of the four-lane serial transmitter.
//
// The implementer's own choice: strobed register access.
`default_nettype none

module sdlcr_regs
    import sdlcr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output var  logic [DATA_W-1:0] rdata_o,
    output var  logic [SEL_W-1:0]  lane0_deemph_sel_o,
    output var  logic [SEL_W-1:0]  lane1_deemph_sel_o,
    output var  logic [SEL_W-1:0]  lane2_deemph_sel_o,
    output var  logic [SEL_W-1:0]  lane3_deemph_sel_o,
    output var  logic [STEP_W-1:0] lane0_deemph_steps_o,
    output var  logic [STEP_W-1:0] lane1_deemph_steps_o,
    output var  logic [STEP_W-1:0] lane2_deemph_steps_o,
    output var  logic [STEP_W-1:0] lane3_deemph_steps_o,
    output var  logic [3:0]        deemph_code_ok_o,
    output var  logic [1:0]        tx_pll_multiplier_sel_o,
    output var  logic              pll_mult_20x_o,
    output var  logic              pll_mult_40x_o,
    output var  logic              pll_reset_o,
    output var  logic              pll_reset_pulsed_o,
    output var  logic              unused_lane_off_o,
    output var  logic              chan_a_lane_zero_oe_o,
    output var  logic              chan_a_lane_three_oe_o,
    output var  logic              chan_b_lane_zero_oe_o,
    output var  logic              chan_b_lane_three_oe_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage; lane index order is 0, 1, 2, 3.
    logic [SEL_W-1:0] deemph_sel [4];
    logic [1:0]       pll_mult;
    logic             pll_rst;
    logic             lane_off_hi;
    logic             lane_off_lo;
    logic             rsvd_seen;
    sdlcr_pr_state_t  pr_state;

    logic [SEL_W-1:0] next_deemph_sel [4];
    logic [1:0]       next_pll_mult;
    logic             next_pll_rst;
    logic             next_lane_off_hi;
    logic             next_lane_off_lo;
    logic             next_rsvd_seen;
    sdlcr_pr_state_t  next_pr_state;

    logic [7:0] lane_off [4];
    logic       wr_deemph [4];
    logic       wr_mult;
    logic       wr_rstpd;
    logic       wr_status;
    logic       rsvd_hit;

    assign lane_off[0] = LANE0_DEEMPH_OFF;
    assign lane_off[1] = LANE1_DEEMPH_OFF;
    assign lane_off[2] = LANE2_DEEMPH_OFF;
    assign lane_off[3] = LANE3_DEEMPH_OFF;

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode and per-lane de-emphasis storage.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [STEP_W-1:0] steps;
            logic [SEL_W-1:0]  sel;
            logic              ok;

            assign wr_deemph[g] = wr_i && (addr_i == lane_off[g]);

            always_comb begin
                next_deemph_sel[g] = deemph_sel[g];
                if (wr_deemph[g]) begin
                    next_deemph_sel[g] = wdata_i[DEEMPH_MSB:DEEMPH_LSB];
                end
            end

            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    deemph_sel[g] <= DEEMPH_RST;
                end else begin
                    deemph_sel[g] <= next_deemph_sel[g];
                end
            end

            sdlcr_lane_drv #(
                .SW (SEL_W)
            ) u_lane (
                .clk_i       (clk_i),
                .rstn_i      (rstn_i),
                .sel_i       (next_deemph_sel[g]),
                .sel_o       (sel),
                .steps_o     (steps),
                .thermo_ok_o (ok)
            );
        end
    endgenerate

    assign lane0_deemph_sel_o   = g_lane[0].sel;
    assign lane1_deemph_sel_o   = g_lane[1].sel;
    assign lane2_deemph_sel_o   = g_lane[2].sel;
    assign lane3_deemph_sel_o   = g_lane[3].sel;
    assign lane0_deemph_steps_o = g_lane[0].steps;
    assign lane1_deemph_steps_o = g_lane[1].steps;
    assign lane2_deemph_steps_o = g_lane[2].steps;
    assign lane3_deemph_steps_o = g_lane[3].steps;
    // One word-wide assignment keeps a single driver on the code check output.
    assign deemph_code_ok_o     = {g_lane[3].ok, g_lane[2].ok, g_lane[1].ok, g_lane[0].ok};

    assign wr_mult   = wr_i && (addr_i == PLL_MULT_OFF);
    assign wr_rstpd  = wr_i && (addr_i == PLL_RST_PD_OFF);
    assign wr_status = wr_i && (addr_i == STATUS_OFF);

    // Reserved bits written as one are remembered so that bring-up software can be caught.
    always_comb begin
        rsvd_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (wr_deemph[i] && |(wdata_i & ~DEEMPH_MASK)) begin
                rsvd_hit = 1'b1;
            end
        end
        if (wr_mult && |(wdata_i & ~PLL_MULT_MASK)) begin
            rsvd_hit = 1'b1;
        end
        if (wr_rstpd && |(wdata_i & ~PLL_RST_MASK)) begin
            rsvd_hit = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // PLL and power-down control storage.
    always_comb begin
        next_pll_mult    = pll_mult;
        next_pll_rst     = pll_rst;
        next_lane_off_hi = lane_off_hi;
        next_lane_off_lo = lane_off_lo;
        next_rsvd_seen   = rsvd_seen;
        if (wr_mult) begin
            next_pll_mult = wdata_i[PLL_MULT_MSB:PLL_MULT_LSB];
        end
        if (wr_rstpd) begin
            next_pll_rst     = wdata_i[PLL_RST_BIT];
            next_lane_off_hi = wdata_i[LANE_OFF_HI_BIT];
            next_lane_off_lo = wdata_i[LANE_OFF_LO_BIT];
        end
        // A new violation in the clearing cycle keeps the flag set.
        if (wr_status && wdata_i[ST_RSVD_BIT]) begin
            next_rsvd_seen = 1'b0;
        end
        if (rsvd_hit) begin
            next_rsvd_seen = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_mult    <= PLL_MULT_RST;
            pll_rst     <= 1'b0;
            lane_off_hi <= 1'b0;
            lane_off_lo <= 1'b0;
            rsvd_seen   <= 1'b0;
        end else begin
            pll_mult    <= next_pll_mult;
            pll_rst     <= next_pll_rst;
            lane_off_hi <= next_lane_off_hi;
            lane_off_lo <= next_lane_off_lo;
            rsvd_seen   <= next_rsvd_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tracks the 0, 1, 0 pulse of the PLL reset bit.
    always_comb begin
        next_pr_state = pr_state;
        unique case (pr_state)
            SDLCR_PR_IDLE: begin
                if (next_pll_rst) begin
                    next_pr_state = SDLCR_PR_HIGH;
                end
            end
            SDLCR_PR_HIGH: begin
                if (!next_pll_rst) begin
                    next_pr_state = SDLCR_PR_DONE;
                end
            end
            SDLCR_PR_DONE: begin
                if (next_pll_rst) begin
                    next_pr_state = SDLCR_PR_HIGH;
                end
            end
            default: begin
                next_pr_state = SDLCR_PR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pr_state <= SDLCR_PR_IDLE;
        end else begin
            pr_state <= next_pr_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered control outputs, updated in the same edge as the register itself.
    logic next_lane_down;

    // Both bits must be set, so a half-written pair never floats the lanes.
    assign next_lane_down = next_lane_off_hi && next_lane_off_lo;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_pll_multiplier_sel_o <= PLL_MULT_RST;
            pll_mult_20x_o          <= 1'b1;
            pll_mult_40x_o          <= 1'b0;
            pll_reset_o             <= 1'b0;
            pll_reset_pulsed_o      <= 1'b0;
            unused_lane_off_o       <= 1'b0;
            chan_a_lane_zero_oe_o   <= 1'b1;
            chan_a_lane_three_oe_o  <= 1'b1;
            chan_b_lane_zero_oe_o   <= 1'b1;
            chan_b_lane_three_oe_o  <= 1'b1;
        end else begin
            tx_pll_multiplier_sel_o <= next_pll_mult;
            pll_mult_20x_o          <= (next_pll_mult == PLL_MULT_20X);
            pll_mult_40x_o          <= (next_pll_mult == PLL_MULT_40X);
            pll_reset_o             <= next_pll_rst;
            pll_reset_pulsed_o      <= (next_pr_state == SDLCR_PR_DONE);
            unused_lane_off_o       <= next_lane_down;
            chan_a_lane_zero_oe_o   <= !next_lane_down;
            chan_a_lane_three_oe_o  <= !next_lane_down;
            chan_b_lane_zero_oe_o   <= !next_lane_down;
            chan_b_lane_three_oe_o  <= !next_lane_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path; reserved bits and unmapped offsets read as zero.
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] status_word;
    logic              bad_code;

    // An unused multiplier code leaves the PLL without a valid ratio, so it is flagged.
    assign bad_code = (pll_mult != PLL_MULT_20X) && (pll_mult != PLL_MULT_40X);

    always_comb begin
        status_word                 = 8'h00;
        status_word[ST_PD_BIT]      = lane_off_hi && lane_off_lo;
        status_word[ST_BADCODE_BIT] = bad_code;
        status_word[ST_PULSED_BIT]  = (pr_state == SDLCR_PR_DONE);
        status_word[ST_RSVD_BIT]    = rsvd_seen;
    end

    // Read data falls back to zero after one cycle, so a stale value never looks like a fresh read.
    always_comb begin
        next_rdata = RDATA_RST;
        if (rd_i) begin
            for (int i = 0; i < 4; i++) begin
                if (addr_i == lane_off[i]) begin
                    next_rdata = {deemph_sel[i], 2'h0};
                end
            end
            if (addr_i == PLL_MULT_OFF) begin
                next_rdata = {6'h00, pll_mult};
            end
            if (addr_i == PLL_RST_PD_OFF) begin
                next_rdata = {1'b0, pll_rst, lane_off_hi, 1'b0, lane_off_lo, 3'h0};
            end
            if (addr_i == STATUS_OFF) begin
                next_rdata = status_word;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= RDATA_RST;
        end else begin
            rdata_o <= next_rdata;
        end
    end

endmodule : sdlcr_regs

`default_nettype wire

// >>> verification/sdlcr_lane_rx_model.sv
// Far-end lane receiver model that sees each lane line level.
`default_nettype none

module sdlcr_lane_rx_model (
    input  wire logic [3:0] oe_i,
    output var  logic [3:0] lane_seen_o
);
    // Released lines sink to low, so a stale driven level cannot pass as live.
    tri0 [3:0] lane_line;
    ////////////////////////////////////////
    for (genvar n = 0; n < 4; n++) begin : g_lane
        assign lane_line[n] = oe_i[n] ? 1'b1 : 1'bz;
    end
    always_comb begin
        lane_seen_o = lane_line;
    end
endmodule : sdlcr_lane_rx_model

`default_nettype wire

// >>> verification/sdlcr_regs_monitor.sv
// Checker of the lane configuration bank at the ports of its top module.
`default_nettype none

module sdlcr_regs_monitor (
    input wire logic       clk_i,
    input wire logic       rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [5:0] lane0_deemph_sel_o,
    input wire logic [5:0] lane1_deemph_sel_o,
    input wire logic [5:0] lane2_deemph_sel_o,
    input wire logic [2:0] lane1_deemph_steps_o,
    input wire logic [3:0] deemph_code_ok_o,
    input wire logic [1:0] tx_pll_multiplier_sel_o,
    input wire logic       pll_mult_20x_o,
    input wire logic       pll_mult_40x_o,
    input wire logic       unused_lane_off_o,
    input wire logic       chan_a_lane_zero_oe_o,
    input wire logic       chan_b_lane_three_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////
    sequence s_wr(a);
        wr_i && addr_i == a;
    endsequence
    sequence s_pd_both;
        s_wr(8'h17) ##0 (wdata_i[5] && wdata_i[3]);
    endsequence
    sequence s_pd_one;
        s_wr(8'h17) ##0 (wdata_i[5] != wdata_i[3]);
    endsequence
    property p_lane0;
        s_wr(8'h13) |=> lane0_deemph_sel_o == $past(wdata_i[7:2]);
    endproperty
    property p_iso;
        s_wr(8'h13) |=> $stable(lane1_deemph_sel_o) && $stable(lane2_deemph_sel_o);
    endproperty
    property p_lane1;
        s_wr(8'h12) |=> lane1_deemph_sel_o == $past(wdata_i[7:2]);
    endproperty
    property p_thermo;
        s_wr(8'h12) ##0 (wdata_i[7:2] == 6'h3f) |=> lane1_deemph_steps_o == 3'h6 && deemph_code_ok_o[1];
    endproperty
    property p_m40;
        tx_pll_multiplier_sel_o == 2'h2 |-> pll_mult_40x_o && !pll_mult_20x_o;
    endproperty
    property p_m20;
        tx_pll_multiplier_sel_o == 2'h0 |-> pll_mult_20x_o && !pll_mult_40x_o;
    endproperty
    property p_pd_on;
        s_pd_both |=> unused_lane_off_o && !chan_a_lane_zero_oe_o && !chan_b_lane_three_oe_o;
    endproperty
    property p_pd_one;
        s_pd_one |=> !unused_lane_off_o && chan_a_lane_zero_oe_o;
    endproperty
    property p_oe;
        chan_a_lane_zero_oe_o == chan_b_lane_three_oe_o && unused_lane_off_o != chan_a_lane_zero_oe_o;
    endproperty
    property p_rd_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_lane0: assert property (p_lane0) else $error("lane 0 select not loaded");
    a_iso: assert property (p_iso) else $error("other lane select moved");
    a_lane1: assert property (p_lane1) else $error("lane 1 select not loaded");
    a_thermo: assert property (p_thermo) else $error("full code step count wrong");
    a_m40: assert property (p_m40) else $error("40x decode wrong");
    a_m20: assert property (p_m20) else $error("20x decode wrong");
    a_pd_on: assert property (p_pd_on) else $error("lanes not released");
    a_pd_one: assert property (p_pd_one) else $error("single bit powered down");
    a_oe: assert property (p_oe) else $error("lane enables disagree");
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule : sdlcr_regs_monitor

bind sdlcr_regs sdlcr_regs_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .lane0_deemph_sel_o(lane0_deemph_sel_o), .lane1_deemph_sel_o(lane1_deemph_sel_o),
    .lane2_deemph_sel_o(lane2_deemph_sel_o), .lane1_deemph_steps_o(lane1_deemph_steps_o),
    .deemph_code_ok_o(deemph_code_ok_o), .tx_pll_multiplier_sel_o(tx_pll_multiplier_sel_o),
    .pll_mult_20x_o(pll_mult_20x_o), .pll_mult_40x_o(pll_mult_40x_o),
    .unused_lane_off_o(unused_lane_off_o), .chan_a_lane_zero_oe_o(chan_a_lane_zero_oe_o),
    .chan_b_lane_three_oe_o(chan_b_lane_three_oe_o));

`default_nettype wire

// >>> verification/sdlcr_regs_tb.sv
// Self-checking bench of the lane configuration register bank.
`default_nettype none

module sdlcr_regs_tb
    import sdlcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] LANE_ADDR [4] = '{LANE0_DEEMPH_OFF, LANE1_DEEMPH_OFF, LANE2_DEEMPH_OFF, LANE3_DEEMPH_OFF};
    logic            clk_i = 1'b0;
    logic            rstn_i = 1'b0;
    logic [7:0]      addr_i = 8'h00;
    logic [7:0]      wdata_i = 8'h00;
    logic            wr_i = 1'b0;
    logic            rd_i = 1'b0;
    logic [7:0]      rdata_o;
    wire [3:0][5:0]  sel;
    wire [3:0][2:0]  steps;
    logic [3:0]      ok_o;
    wire [3:0]       oe;
    logic [3:0]      seen;
    logic [1:0]      mult;
    logic            m20, m40, prst, pulsed, pdoff;
    logic            pr_hi = 1'b0;
    logic            pulse_done = 1'b0;
    logic [7:0]      shadow [8'h12:8'h17];
    logic [7:0]      a, d;
    int              seed = 32'h0000_23e8;
    int              num_errors = 0;
    int              check_count = 0;
    int              cycles = 0;
    ////////////////////////////////////////
    sdlcr_regs DUT (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .lane0_deemph_sel_o(sel[0]), .lane1_deemph_sel_o(sel[1]),
        .lane2_deemph_sel_o(sel[2]), .lane3_deemph_sel_o(sel[3]), .lane0_deemph_steps_o(steps[0]),
        .lane1_deemph_steps_o(steps[1]), .lane2_deemph_steps_o(steps[2]), .lane3_deemph_steps_o(steps[3]),
        .deemph_code_ok_o(ok_o), .tx_pll_multiplier_sel_o(mult), .pll_mult_20x_o(m20), .pll_mult_40x_o(m40),
        .pll_reset_o(prst), .pll_reset_pulsed_o(pulsed), .unused_lane_off_o(pdoff),
        .chan_a_lane_zero_oe_o(oe[0]), .chan_a_lane_three_oe_o(oe[1]), .chan_b_lane_zero_oe_o(oe[2]),
        .chan_b_lane_three_oe_o(oe[3]));
    sdlcr_lane_rx_model u_rx (.oe_i(oe), .lane_seen_o(seen));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    function automatic logic [7:0] wmask(input logic [7:0] x);
        case (x)
            8'h12, 8'h13, 8'h14, 8'h15: wmask = DEEMPH_MASK;
            8'h16: wmask = PLL_MULT_MASK;
            8'h17: wmask = PLL_RST_MASK;
            default: wmask = 8'h00;
        endcase
    endfunction : wmask
    function automatic logic [7:0] rexp(input logic [7:0] x);
        rexp = (wmask(x) != 8'h00) ? shadow[x] : 8'h00;
        if (x == STATUS_OFF) rexp = {5'h00, pulse_done, 1'b0, shadow[8'h17][5] & shadow[8'h17][3]};
    endfunction : rexp
    function automatic logic [2:0] ones(input logic [5:0] v);
        ones = 3'h0;
        for (int i = 0; i < 6; i++) ones = ones + {2'h0, v[i]};
    endfunction : ones
    task automatic chk(input logic [7:0] got, input logic [7:0] exp_v);
        check_count++;
        if (got !== exp_v) begin
            num_errors++;
            $display("ERROR %0t saw %h expected %h", $time, got, exp_v);
        end
    endtask : chk
    task automatic wr(input logic [7:0] x, input logic [7:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= x;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (wmask(x) != 8'h00) shadow[x] = v & wmask(x);
        if (x == PLL_RST_PD_OFF) begin
            pulse_done = !v[PLL_RST_BIT] && (pulse_done || pr_hi);
            pr_hi = v[PLL_RST_BIT];
        end
    endtask : wr
    task automatic rd(input logic [7:0] x);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= x;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, rexp(x));
    endtask : rd
    task automatic outs;
        logic       pd;
        logic [5:0] c;
        @(negedge clk_i);
        pd = shadow[8'h17][5] & shadow[8'h17][3];
        for (int n = 0; n < 4; n++) begin
            c = shadow[LANE_ADDR[n]][7:2];
            chk({2'h0, sel[n]}, {2'h0, c});
            chk({5'h0, steps[n]}, {5'h0, ones(c)});
            chk({7'h0, ok_o[n]}, {7'h0, ((c + 6'h01) & c) == 6'h00});
        end
        chk({4'h0, oe}, {4'h0, {4{!pd}}});
        chk({4'h0, seen}, {4'h0, {4{!pd}}});
        chk({7'h0, pdoff}, {7'h0, pd});
        chk({6'h0, mult}, {6'h0, shadow[8'h16][1:0]});
        chk({6'h0, m40, m20}, {6'h0, shadow[8'h16][1:0] == 2'h2, shadow[8'h16][1:0] == 2'h0});
        chk({6'h0, prst, pulsed}, {6'h0, shadow[8'h17][6], pulse_done});
    endtask : outs
    task automatic summarize;
        if (num_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        for (int i = 8'h12; i <= 8'h17; i++) shadow[i] = 8'h00;
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        outs();
        chk({6'h0, prst, pulsed}, 8'h00);
        for (int i = 8'h12; i <= 8'h18; i++) rd(i[7:0]);
        rd(8'h20);
        // Every thermometer step on lane 1, then a code with a gap.
        for (int i = 0; i < 8; i++) begin
            wr(LANE1_DEEMPH_OFF, (i < 7) ? ((8'h01 << i) - 8'h01) << 2 : 8'h08);
            outs();
        end
        // Only the two legal multiplier codes are written.
        foreach (LANE_ADDR[i]) begin
            wr(PLL_MULT_OFF, {6'h00, i[0], 1'b0});
            outs();
        end
        // Each power-down bit alone, both together, then none.
        foreach (LANE_ADDR[i]) begin
            wr(PLL_RST_PD_OFF, {2'h0, ~i[0], 1'b0, i[1] ^ i[0], 3'h0});
            outs();
            rd(PLL_RST_PD_OFF);
        end
        // Reset pulse of the transmitter PLL written as 0, 1, 0.
        wr(PLL_RST_PD_OFF, 8'h00);
        wr(PLL_RST_PD_OFF, 8'h40);
        @(negedge clk_i);
        chk({6'h0, prst, pulsed}, 8'h02);
        wr(PLL_RST_PD_OFF, 8'h00);
        @(negedge clk_i);
        chk({6'h0, prst, pulsed}, 8'h01);
        rd(STATUS_OFF);
        // Reset in mid-run, then every output is back at its idle value.
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int i = 8'h12; i <= 8'h17; i++) shadow[i] = 8'h00;
        pr_hi = 1'b0;
        pulse_done = 1'b0;
        outs();
        rd(STATUS_OFF);
        // Random traffic with reserved bits kept at zero.
        for (int i = 0; i < 60; i++) begin
            d = 8'($unsigned($random(seed)) % 8);
            a = (d == 8'h07) ? 8'h20 : 8'h12 + d;
            d = 8'($random(seed)) & wmask(a);
            if (a == PLL_MULT_OFF) d = {6'h00, d[1], 1'b0};
            wr(a, d);
            outs();
            rd(a);
        end
        summarize();
    end
endmodule : sdlcr_regs_tb

`default_nettype wire
